// File: nfh_pkg.sv
package nfh_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Power-up recovery wait
	localparam int unsigned POWERUP_WAIT_US = 1000;
	localparam int unsigned POWERUP_CYC = (POWERUP_WAIT_US * 1000) / CLK_PERIOD_NS;
	// Gap from last address rise to first data rise
	localparam int unsigned ADDR_DATA_GAP_NS = 70;
	localparam int unsigned ADDR_DATA_GAP_CYC = (ADDR_DATA_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Strobe half period and data wait after busy
	localparam int unsigned STROBE_HALF_CYC = 3;
	localparam int unsigned READY_TO_READ_CYC = 3;
	// Busy guard: release from the device within this many cycles or give up
	localparam int unsigned BUSY_TIMEOUT_CYC = 1000;
	localparam int unsigned FEAT_BYTES = 4;
	localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
	localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] FADDR_IO_DRIVE = 8'h80;
	localparam logic [7:0] FADDR_RB_PULL = 8'h81;
	localparam logic [7:0] STRENGTH_MAX = 8'h03;
	localparam int unsigned STATUS_READY_BIT = 5;

	typedef struct packed {
		logic [7:0] p4;
		logic [7:0] p3;
		logic [7:0] p2;
		logic [7:0] p1;
	} nfh_params_t;

	typedef struct packed {
		logic cle;
		logic ale;
		logic ce_n;
		logic we_n;
		logic re_n;
		logic wp_n;
	} nfh_strobes_t;
endpackage

// File: nfh_feature_host.sv
// Function
// - Get features: command EEh then exactly one feature address cycle.
// - Status polling during get features is followed by read command 00h.
// - After ready, one feature byte is taken per read_enable_n pulse.
// - Set features: command EFh then one feature address cycle.
// - Four parameter bytes sent in order, latched on write_enable_n rise.
// - Host holds write_protect_n steady until operation completes, status bit5 high.
// - Host waits at least 1 ms after power-up before any command.
// - Host keeps write_protect_n low through power-up and power-down; power-down is not handled here.
// - At least 70 ns between last address rise and first data rise.
module nfh_feature_host #(
	parameter int unsigned POWERUP_CYCLES = nfh_pkg::POWERUP_CYC
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// User request
	input wire logic i_start,
	input wire logic i_set,
	input wire logic i_poll_status,
	input wire logic [7:0] i_feat_addr,
	input wire nfh_pkg::nfh_params_t i_params,
	input wire logic i_wp_release,
	// User answer
	output logic o_ready,
	output logic o_done,
	output logic o_error,
	output nfh_pkg::nfh_params_t o_params,
	// Flash pins
	output nfh_pkg::nfh_strobes_t o_strobes,
	output logic [7:0] o_io,
	output logic o_io_oe,
	input wire logic [7:0] i_io,
	input wire logic i_ready_busy_n
);
	typedef enum {
		ST_POWERUP, ST_IDLE, ST_CMD, ST_ADDR, ST_GAP, ST_WDATA, ST_BUSY,
		ST_STAT_CMD, ST_STAT_RD, ST_READ_CMD, ST_SETTLE, ST_RDATA, ST_DONE
	} nfh_state_t;

	nfh_state_t state_r, state_nxt;
	logic [19:0] cnt_r, cnt_nxt;
	logic [1:0] byte_r, byte_nxt;
	logic [2:0] ph_r, ph_nxt;
	logic set_r, set_nxt;
	logic poll_r, poll_nxt;
	logic [7:0] addr_r, addr_nxt;
	nfh_pkg::nfh_params_t wparams_r, wparams_nxt;
	nfh_pkg::nfh_params_t rparams_r, rparams_nxt;
	nfh_pkg::nfh_strobes_t strb_r, strb_nxt;
	logic [7:0] io_r, io_nxt;
	logic io_oe_r, io_oe_nxt;
	logic done_r, done_nxt;
	logic err_r, err_nxt;
	logic wp_r, wp_nxt;
	logic stat_ok;

	// Byte of the write set picked by index
	function automatic logic [7:0] pick_byte(input nfh_pkg::nfh_params_t p, input logic [1:0] i);
		pick_byte = p[i*8 +: 8];
	endfunction

	assign stat_ok = i_io[nfh_pkg::STATUS_READY_BIT];

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		byte_nxt = byte_r;
		ph_nxt = ph_r;
		set_nxt = set_r;
		poll_nxt = poll_r;
		addr_nxt = addr_r;
		wparams_nxt = wparams_r;
		rparams_nxt = rparams_r;
		strb_nxt = strb_r;
		io_nxt = io_r;
		io_oe_nxt = io_oe_r;
		done_nxt = 1'b0;
		err_nxt = err_r;
		wp_nxt = wp_r;
		unique case (state_r)
			ST_POWERUP: begin
				// Protect held low until recovery wait ends
				wp_nxt = 1'b0;
				if (cnt_r >= 20'(POWERUP_CYCLES - 1)) begin
					state_nxt = ST_IDLE;
					cnt_nxt = '0;
				end else begin
					cnt_nxt = cnt_r + 20'h00001;
				end
			end
			ST_IDLE: begin
				// Protect level only moves between operations
				wp_nxt = i_wp_release;
				if (i_start) begin
					set_nxt = i_set;
					poll_nxt = i_poll_status;
					addr_nxt = i_feat_addr;
					wparams_nxt = i_params;
					err_nxt = 1'b0;
					io_nxt = i_set ? nfh_pkg::CMD_SET_FEAT : nfh_pkg::CMD_GET_FEAT;
					io_oe_nxt = 1'b1;
					strb_nxt.ce_n = 1'b0;
					strb_nxt.cle = 1'b1;
					ph_nxt = '0;
					state_nxt = ST_CMD;
				end
			end
			ST_CMD, ST_ADDR, ST_WDATA, ST_STAT_CMD, ST_READ_CMD: begin
				// Write strobe: low for half, rising edge latches
				ph_nxt = ph_r + 3'h1;
				if (ph_r == 3'h0) begin
					strb_nxt.we_n = 1'b0;
				end else if (ph_r == 3'(nfh_pkg::STROBE_HALF_CYC)) begin
					strb_nxt.we_n = 1'b1;
				end else if (ph_r == 3'(2 * nfh_pkg::STROBE_HALF_CYC)) begin
					ph_nxt = '0;
					strb_nxt.cle = 1'b0;
					strb_nxt.ale = 1'b0;
					cnt_nxt = '0;
					unique case (state_r)
						ST_CMD: begin
							strb_nxt.ale = 1'b1;
							io_nxt = addr_r;
							state_nxt = ST_ADDR;
						end
						ST_ADDR: begin
							io_oe_nxt = set_r;
							byte_nxt = '0;
							state_nxt = set_r ? ST_GAP : ST_BUSY;
						end
						ST_WDATA: begin
							byte_nxt = byte_r + 2'h1;
							io_nxt = pick_byte(wparams_r, byte_r + 2'h1);
							if (byte_r == 2'(nfh_pkg::FEAT_BYTES - 1)) begin
								io_oe_nxt = 1'b0;
								state_nxt = ST_BUSY;
							end
						end
						ST_STAT_CMD: begin
							io_oe_nxt = 1'b0;
							state_nxt = ST_STAT_RD;
						end
						default: begin
							io_oe_nxt = 1'b0;
							state_nxt = ST_SETTLE;
						end
					endcase
				end
			end
			ST_GAP: begin
				// Counted from end of address cycle, a half after its rise; data rise comes a half plus one cycle later
				cnt_nxt = cnt_r + 20'h00001;
				if (cnt_r >= 20'(nfh_pkg::ADDR_DATA_GAP_CYC)) begin
					io_nxt = pick_byte(wparams_r, 2'h0);
					ph_nxt = '0;
					state_nxt = ST_WDATA;
				end
			end
			ST_BUSY: begin
				// Only status polling is issued while busy
				cnt_nxt = cnt_r + 20'h00001;
				if (cnt_r >= 20'(nfh_pkg::BUSY_TIMEOUT_CYC)) begin
					err_nxt = 1'b1;
					state_nxt = ST_DONE;
				end else if (poll_r && cnt_r == 20'h00002) begin
					io_nxt = nfh_pkg::CMD_READ_STATUS;
					io_oe_nxt = 1'b1;
					strb_nxt.cle = 1'b1;
					ph_nxt = '0;
					state_nxt = ST_STAT_CMD;
				end else if (cnt_r > 20'h00002 && i_ready_busy_n) begin
					state_nxt = set_r ? ST_DONE : ST_SETTLE;
					cnt_nxt = '0;
				end
			end
			ST_STAT_RD: begin
				ph_nxt = ph_r + 3'h1;
				// Bounded like the busy wait: a stuck status must not hang the host
				cnt_nxt = cnt_r + 20'h00001;
				if (cnt_r >= 20'(nfh_pkg::BUSY_TIMEOUT_CYC)) begin
					strb_nxt.re_n = 1'b1;
					err_nxt = 1'b1;
					state_nxt = ST_DONE;
				end else if (ph_r == 3'h0) begin
					strb_nxt.re_n = 1'b0;
				end else if (ph_r == 3'(nfh_pkg::STROBE_HALF_CYC)) begin
					strb_nxt.re_n = 1'b1;
					ph_nxt = '0;
					if (stat_ok) begin
						if (set_r) begin
							state_nxt = ST_DONE;
						end else begin
							// Leave status output mode before fetching data
							io_nxt = nfh_pkg::CMD_READ;
							io_oe_nxt = 1'b1;
							strb_nxt.cle = 1'b1;
							state_nxt = ST_READ_CMD;
						end
					end
				end
			end
			ST_SETTLE: begin
				cnt_nxt = cnt_r + 20'h00001;
				if (cnt_r >= 20'(nfh_pkg::READY_TO_READ_CYC)) begin
					ph_nxt = '0;
					byte_nxt = '0;
					state_nxt = ST_RDATA;
				end
			end
			ST_RDATA: begin
				ph_nxt = ph_r + 3'h1;
				if (ph_r == 3'h0) begin
					strb_nxt.re_n = 1'b0;
				end else if (ph_r == 3'(nfh_pkg::STROBE_HALF_CYC)) begin
					rparams_nxt[byte_r*8 +: 8] = i_io;
					strb_nxt.re_n = 1'b1;
				end else if (ph_r == 3'(2 * nfh_pkg::STROBE_HALF_CYC)) begin
					ph_nxt = '0;
					byte_nxt = byte_r + 2'h1;
					if (byte_r == 2'(nfh_pkg::FEAT_BYTES - 1)) begin
						state_nxt = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				// Deselect between operations; feature mode persists regardless
				strb_nxt.ce_n = 1'b1;
				done_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state_r <= ST_POWERUP;
			cnt_r <= 20'h00000;
			byte_r <= 2'h0;
			ph_r <= 3'h0;
			set_r <= 1'b0;
			poll_r <= 1'b0;
			addr_r <= 8'h00;
			wparams_r <= '0;
			rparams_r <= '0;
			strb_r <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
			io_r <= 8'h00;
			io_oe_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
			wp_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			byte_r <= byte_nxt;
			ph_r <= ph_nxt;
			set_r <= set_nxt;
			poll_r <= poll_nxt;
			addr_r <= addr_nxt;
			wparams_r <= wparams_nxt;
			rparams_r <= rparams_nxt;
			strb_r <= '{cle: strb_nxt.cle, ale: strb_nxt.ale, ce_n: strb_nxt.ce_n,
				we_n: strb_nxt.we_n, re_n: strb_nxt.re_n, wp_n: wp_nxt};
			io_r <= io_nxt;
			io_oe_r <= io_oe_nxt;
			done_r <= done_nxt;
			err_r <= err_nxt;
			wp_r <= wp_nxt;
		end
	end

	logic ready_r;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= (state_nxt == ST_IDLE);
		end
	end

	assign o_ready = ready_r;
	assign o_done = done_r;
	assign o_error = err_r;
	assign o_params = rparams_r;
	assign o_strobes = strb_r;
	assign o_io = io_r;
	assign o_io_oe = io_oe_r;

	////////////////////////////////////////////////////////////////////////
	a_wp_low_powerup: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(state_r == ST_POWERUP) |-> !o_strobes.wp_n)
		else $error("write protect not low during power-up");
	a_no_cmd_early: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(state_r == ST_POWERUP) |-> o_strobes.ce_n && !o_strobes.cle)
		else $error("command before recovery wait");
	a_wp_steady_op: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(state_r != ST_IDLE && $past(state_r) != ST_IDLE) |-> $stable(o_strobes.wp_n))
		else $error("write protect moved during operation");
	a_cmd_then_addr: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(state_r == ST_CMD && state_nxt == ST_ADDR) |=> o_strobes.ale && o_io == addr_r)
		else $error("address cycle not after command");
	a_gap_kept: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(state_r == ST_ADDR && state_nxt == ST_GAP) |=> (state_r == ST_GAP && o_strobes.we_n) [*8])
		else $error("address to data gap too short");
	a_busy_no_cmd: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(state_r == ST_BUSY) |=> (!o_strobes.cle || o_io == nfh_pkg::CMD_READ_STATUS))
		else $error("command other than status during busy");
	a_read_after_stat: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(state_r == ST_STAT_RD && state_nxt == ST_READ_CMD) |=> o_io == nfh_pkg::CMD_READ)
		else $error("read command missing after status");
	a_four_bytes: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(state_r == ST_WDATA && state_nxt == ST_BUSY) |-> byte_r == 2'h3)
		else $error("parameter byte count wrong");
endmodule

// File: nfh_flash_model.sv
module nfh_flash_model #(
	parameter int unsigned WAKE_NS = 300
) (
	// Host strobes and data
	input wire nfh_pkg::nfh_strobes_t i_strobes,
	input wire logic [7:0] i_io,
	input wire logic i_io_oe,
	input wire logic [31:0] i_busy_ns,
	// Device answer
	output logic [7:0] o_io,
	output logic o_ready_busy_n,
	output int o_faults
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] feat [256];
	logic [31:0] shadow;
	logic [31:0] outw;
	logic [7:0] cmd;
	logic [7:0] addr;
	logic [7:0] last;
	int nbytes;
	int ridx;
	int naddr;
	bit status_mode;
	realtime t_addr;
	initial begin
		o_io = 8'hA5;
		o_ready_busy_n = 1'b1;
		o_faults = 0;
		cmd = 8'hFF;
		status_mode = 1'b0;
		foreach (feat[i]) feat[i] = 32'h00000000;
	end
	////////////////////////////////////////////////////////////////////////////
	task go_busy();
		fork
			begin
				#5 o_ready_busy_n = 1'b0;
				#(i_busy_ns) o_ready_busy_n = 1'b1;
			end
		join_none
	endtask
	// Protect pin: low through wake-up, frozen while busy
	always @(i_strobes.wp_n) begin
		if ($realtime < WAKE_NS && i_strobes.wp_n === 1'b1) o_faults++;
		if (o_ready_busy_n === 1'b0) o_faults++;
	end
	always @(posedge i_strobes.we_n) begin
		if (i_strobes.ce_n === 1'b0) begin
			if (i_strobes.cle === 1'b1) begin
				if ($realtime < WAKE_NS) o_faults++;
				// Host must never reach array, OTP, program or erase commands
				if (!(i_io inside {8'h00, 8'h70, 8'hEE, 8'hEF})) o_faults++;
				if (!o_ready_busy_n && i_io !== 8'h70) o_faults++;
				if (i_io === 8'h70) status_mode = 1'b1;
				else if (i_io === 8'h00 && cmd === 8'hEE) status_mode = 1'b0;
				else begin
					// Any other command leaves feature mode; table is kept
					cmd = i_io;
					naddr = 0;
					nbytes = 0;
					status_mode = 1'b0;
				end
			end else if (i_strobes.ale === 1'b1) begin
				naddr++;
				addr = i_io;
				t_addr = $realtime;
				if (naddr > 1) o_faults++;
				if (cmd === 8'hEE && naddr == 1) begin
					outw = feat[addr];
					ridx = 0;
					go_busy();
				end
			end else if (cmd === 8'hEF && nbytes < 4) begin
				if (nbytes == 0 && $realtime - t_addr < 70) o_faults++;
				shadow[8*nbytes +: 8] = i_io;
				nbytes++;
				if (nbytes == 4) begin
					feat[addr] = shadow;
					go_busy();
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	always @(negedge i_strobes.re_n) begin
		if (i_strobes.ce_n === 1'b0) begin
			if (i_io_oe === 1'b1) o_faults++;
			if (status_mode) o_io = {i_strobes.wp_n, o_ready_busy_n, o_ready_busy_n, 5'h00};
			else begin
				o_io = outw[8*ridx +: 8];
				ridx = (ridx + 1) % 4;
			end
		end
	end
	// No pull on the bus: after hold time show the inverse, not the old byte
	always @(posedge i_strobes.re_n) begin
		last = o_io;
		// A new read may start inside the hold time; keep its byte
		#15 if (i_strobes.re_n === 1'b1) o_io = ~last;
	end
endmodule

// File: nfh_feature_host_tb_top.sv
module nfh_feature_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic set_op = 1'b0;
	logic poll = 1'b0;
	logic wp_release = 1'b0;
	logic [7:0] feat_addr = 8'h80;
	nfh_pkg::nfh_params_t params = '0;
	logic ready;
	logic done;
	logic err;
	nfh_pkg::nfh_params_t rd_params;
	nfh_pkg::nfh_strobes_t strobes;
	logic [7:0] io_out;
	logic [7:0] io_in;
	logic io_oe;
	logic rb_n;
	logic [31:0] busy_ns = 32'd600;
	int faults;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #5 clk_sys = ~clk_sys;
	nfh_feature_host #(.POWERUP_CYCLES(20)) DUT (.i_clk_sys(clk_sys), .i_reset(reset),
		.i_start(start), .i_set(set_op), .i_poll_status(poll), .i_feat_addr(feat_addr),
		.i_params(params), .i_wp_release(wp_release), .o_ready(ready), .o_done(done),
		.o_error(err), .o_params(rd_params), .o_strobes(strobes), .o_io(io_out),
		.o_io_oe(io_oe), .i_io(io_in), .i_ready_busy_n(rb_n));
	nfh_flash_model #(.WAKE_NS(300)) u_dev (.i_strobes(strobes), .i_io(io_out),
		.i_io_oe(io_oe), .i_busy_ns(busy_ns), .o_io(io_in), .o_ready_busy_n(rb_n),
		.o_faults(faults));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task give_verdict();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			give_verdict();
		end
	end
	// Start one operation and wait for its end or its busy timeout
	task automatic run_op(input logic s, input logic p, input logic [7:0] a,
		input logic [31:0] prm);
		int n;
		n = 0;
		do begin @(negedge clk_sys); n++; end while (ready !== 1'b1 && n < 3000);
		check("ready seen", {31'h0, ready}, 32'h1);
		@(posedge clk_sys);
		start <= 1'b1;
		set_op <= s;
		poll <= p;
		feat_addr <= a;
		params <= prm;
		@(posedge clk_sys);
		start <= 1'b0;
		n = 0;
		do begin @(negedge clk_sys); n++; end while (done !== 1'b1 && err !== 1'b1 && n < 3000);
		check("op end", {31'h0, done | err}, 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task t_set_get();
		for (int a = 0; a < 2; a++) begin
			for (int c = 0; c < 4; c++) begin
				run_op(1'b1, c[0], 8'h80 + a[7:0], {24'h000000, c[7:0]});
				check("set end", {31'h0, err}, 32'h0);
				run_op(1'b0, c[1], 8'h80 + a[7:0], 32'h0);
				check("get data", rd_params, {24'h000000, c[7:0]});
			end
		end
		$display("test set_get done");
	endtask
	task t_persist();
		run_op(1'b1, 1'b0, 8'h80, 32'h00000002);
		run_op(1'b1, 1'b1, 8'h81, 32'h00000001);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (3) @(negedge clk_sys);
		check("wp in reset", {31'h0, strobes.wp_n}, 32'h0);
		check("ce in reset", {31'h0, strobes.ce_n}, 32'h1);
		@(posedge clk_sys);
		reset <= 1'b0;
		run_op(1'b0, 1'b0, 8'h80, 32'h0);
		check("kept 80h", rd_params, 32'h00000002);
		run_op(1'b0, 1'b1, 8'h81, 32'h0);
		check("kept 81h", rd_params, 32'h00000001);
		$display("test persist done");
	endtask
	task t_protect();
		@(posedge clk_sys);
		wp_release <= 1'b1;
		run_op(1'b0, 1'b0, 8'h80, 32'h0);
		check("wp released", {31'h0, strobes.wp_n}, 32'h1);
		@(posedge clk_sys);
		wp_release <= 1'b0;
		run_op(1'b0, 1'b1, 8'h80, 32'h0);
		check("wp held", {31'h0, strobes.wp_n}, 32'h0);
		$display("test protect done");
	endtask
	task t_slow_busy();
		int n;
		@(posedge clk_sys);
		busy_ns <= 32'd12000;
		run_op(1'b0, 1'b0, 8'h81, 32'h0);
		check("busy timeout", {31'h0, err}, 32'h1);
		n = 0;
		while (rb_n !== 1'b1 && n < 2000) begin @(negedge clk_sys); n++; end
		@(posedge clk_sys);
		busy_ns <= 32'd600;
		run_op(1'b0, 1'b0, 8'h81, 32'h0);
		check("error cleared", {31'h0, err}, 32'h0);
		check("after timeout", rd_params, 32'h00000001);
		$display("test slow_busy done");
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		t_set_get();
		t_persist();
		t_protect();
		t_slow_busy();
		check("device faults", faults, 32'h0);
		give_verdict();
	end
endmodule
